// ### hw/waveform_pair.sv
`timescale 1ns/1ps
module waveform_pair
(
	// Clock and reset
	input  wire logic                              i_mclk,
	input  wire logic                              i_rst_n,
	input  wire logic                              i_tick,
	// Configuration
	input  wire waveform_pkg::pair_cfg_t           i_cfg,
	// Sources
	input  wire waveform_pkg::cmp_pair_t           i_cmp,
	input  wire logic                              i_pg,
	// Results
	output logic                                   o_wave_even,
	output logic                                   o_wave_odd,
	output logic                                   o_reload_irq,
	output logic                                   o_timer_busy
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		waveform_pkg::dt_state_t            dt;
		logic [waveform_pkg::TIMER_W-1:0]   wcnt;
		logic                               gate_run;
		logic [waveform_pkg::TIMER_W-1:0]   fcnt;
		logic                               filt;
		logic                               cmp_odd_d;
		logic                               wave_even;
		logic                               wave_odd;
		logic                               irq;
	} pair_state_t;

	pair_state_t st_q;
	pair_state_t st_d;

	logic dead_mode;
	logic filt_mode;
	logic dt_src;
	logic raw_src;

	always_comb
	begin
		dead_mode = i_cfg.mode[2];
		filt_mode = (i_cfg.mode == waveform_pkg::MODE_CMP_DEAD_F) ||
		            (i_cfg.mode == waveform_pkg::MODE_PG_DEAD_F);
		raw_src   = (i_cfg.mode == waveform_pkg::MODE_PG_DEAD ||
		             i_cfg.mode == waveform_pkg::MODE_PG_DEAD_F) ? i_pg : i_cmp.odd;
		dt_src    = filt_mode ? st_q.filt : raw_src;
	end

	always_comb
	begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.cmp_odd_d = i_cmp.odd;

		// ------------------------------------------------------------
		// Pulse counter: width filter or reload timer
		// ------------------------------------------------------------
		if (filt_mode)
		begin
			// Level must persist beyond the preset to pass; narrower pulses vanish
			if (raw_src == st_q.filt)
				st_d.fcnt = waveform_pkg::RST_COUNT;
			else if (i_tick)
			begin
				if (st_q.fcnt >= i_cfg.pulse_filter_preset)
				begin
					st_d.filt = raw_src;
					st_d.fcnt = waveform_pkg::RST_COUNT;
				end
				else
					st_d.fcnt = st_q.fcnt + 16'h0001;
			end
		end
		else
		begin
			st_d.filt = raw_src;
			if (i_cfg.reload_enable && i_tick)
			begin
				if (st_q.fcnt >= i_cfg.pulse_filter_preset)
				begin
					st_d.fcnt = waveform_pkg::RST_COUNT;
					st_d.irq  = 1'b1;
				end
				else
					st_d.fcnt = st_q.fcnt + 16'h0001;
			end
			else if (!i_cfg.reload_enable)
				st_d.fcnt = waveform_pkg::RST_COUNT;
		end

		// ------------------------------------------------------------
		// Waveform timer
		// ------------------------------------------------------------
		if (dead_mode)
		begin
			st_d.gate_run = 1'b0;
			case (st_q.dt)
				waveform_pkg::DT_LOW:
				begin
					st_d.wcnt = waveform_pkg::RST_COUNT;
					if (dt_src)
						st_d.dt = waveform_pkg::DT_DEADA;
				end
				waveform_pkg::DT_DEADA:
				begin
					if (!dt_src)
						st_d.dt = waveform_pkg::DT_LOW;
					else if (i_tick)
					begin
						if (st_q.wcnt + 16'h0001 >= i_cfg.timer_preset_a)
							st_d.dt = waveform_pkg::DT_HIGH;
						st_d.wcnt = st_q.wcnt + 16'h0001;
					end
				end
				waveform_pkg::DT_HIGH:
				begin
					st_d.wcnt = waveform_pkg::RST_COUNT;
					if (!dt_src)
						st_d.dt = waveform_pkg::DT_DEADB;
				end
				waveform_pkg::DT_DEADB:
				begin
					if (dt_src)
						st_d.dt = waveform_pkg::DT_HIGH;
					else if (i_tick)
					begin
						if (st_q.wcnt + 16'h0001 >= i_cfg.timer_preset_b)
							st_d.dt = waveform_pkg::DT_LOW;
						st_d.wcnt = st_q.wcnt + 16'h0001;
					end
				end
				default:
					st_d.dt = waveform_pkg::DT_LOW;
			endcase
		end
		else
		begin
			st_d.dt = waveform_pkg::DT_LOW;
			// Compare rising edge starts the A+B gate window
			if (i_cfg.mode == waveform_pkg::MODE_TIMER_GATE && i_cmp.odd && !st_q.cmp_odd_d && !st_q.gate_run)
			begin
				st_d.gate_run = 1'b1;
				st_d.wcnt     = waveform_pkg::RST_COUNT;
			end
			else if (st_q.gate_run && i_tick)
			begin
				if (st_q.wcnt + 16'h0001 >= i_cfg.timer_preset_a + i_cfg.timer_preset_b)
				begin
					st_d.gate_run = 1'b0;
					st_d.wcnt     = waveform_pkg::RST_COUNT;
				end
				else
					st_d.wcnt = st_q.wcnt + 16'h0001;
			end
			else if (i_cfg.mode != waveform_pkg::MODE_TIMER_GATE)
				st_d.gate_run = 1'b0;
		end

		// ------------------------------------------------------------
		// Waveform shaping
		// ------------------------------------------------------------
		case (i_cfg.mode)
			waveform_pkg::MODE_THROUGH:
			begin
				st_d.wave_even = i_cmp.even;
				st_d.wave_odd  = i_cmp.odd;
			end
			waveform_pkg::MODE_SUPERPOSE:
			begin
				st_d.wave_even = i_cmp.even & i_pg;
				st_d.wave_odd  = i_cmp.odd & i_pg;
			end
			waveform_pkg::MODE_TIMER_GATE:
			begin
				st_d.wave_even = st_q.gate_run & i_pg;
				st_d.wave_odd  = st_q.gate_run & i_pg;
			end
			default:
			begin
				// Complementary pair; both low through each dead band
				st_d.wave_odd  = (st_d.dt == waveform_pkg::DT_HIGH);
				st_d.wave_even = (st_d.dt == waveform_pkg::DT_LOW) && !dt_src;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_q <= '{dt: waveform_pkg::DT_LOW, default: '0};
		else
			st_q <= st_d;
	end

	assign o_wave_even  = st_q.wave_even;
	assign o_wave_odd   = st_q.wave_odd;
	assign o_reload_irq = st_q.irq;
	assign o_timer_busy = st_q.gate_run || (st_q.dt != waveform_pkg::DT_LOW);

endmodule // waveform_pair

// ### hw/waveform_pkg.sv
package waveform_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int NUM_PAIRS  = 3;
	localparam int NUM_PINS   = 6;
	localparam int TIMER_W    = 16;
	localparam int DIV_SEL_W  = 3;
	localparam int DIV_CNT_W  = 8;
	localparam int PG_SEL_W   = 2;
	localparam int NUM_PG     = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [TIMER_W-1:0]   RST_COUNT = 16'h0000;
	localparam logic [DIV_CNT_W-1:0] RST_DIV   = 8'h00;

	// ----------------------------------------------------------------
	// Waveform modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MODE_THROUGH    = 3'h0,
		MODE_SUPERPOSE  = 3'h1,
		MODE_TIMER_GATE = 3'h2,
		MODE_CMP_DEAD   = 3'h4,
		MODE_CMP_DEAD_F = 3'h5,
		MODE_PG_DEAD    = 3'h6,
		MODE_PG_DEAD_F  = 3'h7
	} wave_mode_t;

	// Per-pair configuration
	typedef struct packed
	{
		wave_mode_t            mode;
		logic [TIMER_W-1:0]    timer_preset_a;
		logic [TIMER_W-1:0]    timer_preset_b;
		logic [TIMER_W-1:0]    pulse_filter_preset;
		logic [PG_SEL_W-1:0]   pg_select;
		logic                  gate_enable;
		logic                  reload_enable;
	} pair_cfg_t;

	// Per-pair source signals from compare unit
	typedef struct packed
	{
		logic even;
		logic odd;
	} cmp_pair_t;

	// Dead-time generator states
	typedef enum logic [3:0]
	{
		DT_LOW   = 4'h1,
		DT_DEADA = 4'h2,
		DT_HIGH  = 4'h4,
		DT_DEADB = 4'h8
	} dt_state_t;

endpackage

// ### hw/waveform_unit.sv
`timescale 1ns/1ps
module waveform_unit
(
	// Clock and reset
	input  wire logic                                      i_mclk,
	input  wire logic                                      i_rst_n,
	// Configuration
	input  wire logic [waveform_pkg::DIV_SEL_W-1:0]        i_div_sel,
	input  wire waveform_pkg::pair_cfg_t [waveform_pkg::NUM_PAIRS-1:0] i_pair_cfg,
	input  wire logic [waveform_pkg::NUM_PINS-1:0]         i_invert,
	input  wire logic [7:0]                                i_nc_width,
	input  wire logic                                      i_nc_bypass,
	input  wire logic                                      i_port_select,
	input  wire logic [waveform_pkg::NUM_PINS-1:0]         i_port_level,
	input  wire logic                                      i_output_hold_select,
	input  wire logic                                      i_shutdown_clear,
	// Compare unit and pulse generators
	input  wire logic [waveform_pkg::NUM_PINS-1:0]         i_compare_output,
	input  wire logic [waveform_pkg::NUM_PG-1:0]           i_pg_pulse,
	// Shutdown request pin, active low
	input  wire logic                                      i_shutdown_request_input_n,
	// Outputs
	output logic [waveform_pkg::NUM_PINS-1:0]              o_waveform_pin,
	output logic [waveform_pkg::NUM_PG-1:0]                o_pg_start,
	output logic [waveform_pkg::NUM_PAIRS-1:0]             o_reload_irq,
	output logic                                           o_shutdown_interrupt
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [waveform_pkg::DIV_CNT_W-1:0]       div;
		logic                                     tick;
		logic [1:0]                               req_sync;
		logic [7:0]                               nc_cnt;
		logic                                     nc_level;
		logic                                     shut;
		logic [waveform_pkg::NUM_PINS-1:0]        held;
		logic [waveform_pkg::NUM_PINS-1:0]        pins;
		waveform_pkg::pair_cfg_t [waveform_pkg::NUM_PAIRS-1:0] cfg;
	} unit_state_t;

	unit_state_t st_q;
	unit_state_t st_d;

	logic [waveform_pkg::NUM_PINS-1:0]  wave;
	logic [waveform_pkg::NUM_PAIRS-1:0] busy;
	logic [waveform_pkg::NUM_PAIRS-1:0] irq;
	logic [waveform_pkg::NUM_PG-1:0]    pg_start;

	function automatic logic pg_pick(input logic [waveform_pkg::NUM_PG-1:0] pg,
	                                 input logic [waveform_pkg::PG_SEL_W-1:0] sel);
		pg_pick = pg[sel];
	endfunction

	// Prescaler terminal count for a ratio of 2^sel
	function automatic logic [waveform_pkg::DIV_CNT_W-1:0] div_limit(input logic [waveform_pkg::DIV_SEL_W-1:0] s);
		div_limit = 8'((9'h001 << s) - 9'h001);
	endfunction

	// ----------------------------------------------------------------
	// Channel pairs
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < waveform_pkg::NUM_PAIRS; p++)
		begin : g_pair
			waveform_pkg::cmp_pair_t cmp;
			assign cmp.even = i_compare_output[2*p];
			assign cmp.odd  = i_compare_output[2*p+1];
			waveform_pair u_pair
			(
				.i_mclk       (i_mclk),
				.i_rst_n      (i_rst_n),
				.i_tick       (st_q.tick),
				.i_cfg        (st_q.cfg[p]),
				.i_cmp        (cmp),
				.i_pg         (pg_pick(i_pg_pulse, st_q.cfg[p].pg_select)),
				.o_wave_even  (wave[2*p]),
				.o_wave_odd   (wave[2*p+1]),
				.o_reload_irq (irq[p]),
				.o_timer_busy (busy[p])
			);
		end
	endgenerate

	always_comb
	begin
		pg_start = '0;
		for (int k = 0; k < waveform_pkg::NUM_PAIRS; k++)
			if (st_q.cfg[k].gate_enable)
				pg_start[st_q.cfg[k].pg_select] = 1'b1;
	end

	always_comb
	begin
		st_d = st_q;

		// Prescaler: ratio 2^sel, one-cycle tick enable
		if (st_q.div >= div_limit(i_div_sel))
		begin
			st_d.div  = waveform_pkg::RST_DIV;
			st_d.tick = 1'b1;
		end
		else
		begin
			st_d.div  = st_q.div + 8'h01;
			st_d.tick = 1'b0;
		end

		// Config loads only while the pair is idle, so a running timer is not corrupted
		for (int k = 0; k < waveform_pkg::NUM_PAIRS; k++)
			if (!busy[k])
				st_d.cfg[k] = i_pair_cfg[k];

		// Noise canceller: level must be stable for more than the width in clocks
		st_d.req_sync = {st_q.req_sync[0], ~i_shutdown_request_input_n};
		if (st_q.req_sync[1] == st_q.nc_level)
			st_d.nc_cnt = 8'h00;
		else if (st_q.nc_cnt >= i_nc_width)
		begin
			st_d.nc_level = st_q.req_sync[1];
			st_d.nc_cnt   = 8'h00;
		end
		else
			st_d.nc_cnt = st_q.nc_cnt + 8'h01;

		// Set wins over software clear
		if (st_q.nc_level)
			st_d.shut = 1'b1;
		else if (i_shutdown_clear)
			st_d.shut = 1'b0;

		// Capture pin level until shutdown asserts
		if (!o_shutdown_interrupt)
			st_d.held = st_q.pins;

		st_d.pins = wave ^ i_invert;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Bypass path is combinational from the pin so it works with the clock stopped
	assign o_shutdown_interrupt = st_q.shut | (i_nc_bypass & ~i_shutdown_request_input_n);

	always_comb
	begin
		if (o_shutdown_interrupt && i_port_select)
			o_waveform_pin = i_port_level;
		else if (o_shutdown_interrupt && i_output_hold_select)
			o_waveform_pin = st_q.held;
		else
			o_waveform_pin = st_q.pins;
	end

	assign o_pg_start   = pg_start;
	assign o_reload_irq = irq;

endmodule // waveform_unit

// ### verification/waveform_partner.sv
`timescale 1ns/1ps
module waveform_partner
#(
	parameter int PG_HALF = 3
)
(
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	// Requests
	input  wire logic [5:0] i_cmp_level,
	input  wire logic [3:0] i_pg_start,
	// Sources
	output logic      [5:0] o_compare_output,
	output logic      [3:0] o_pg_pulse
);
	int cnt_q [4];

	// Generators sit low until started, so a lost start shows at the pins
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_compare_output <= 6'h00;
			o_pg_pulse       <= 4'h0;
			for (int k = 0; k < 4; k++)
				cnt_q[k] <= 0;
		end
		else
		begin
			o_compare_output <= i_cmp_level;
			for (int k = 0; k < 4; k++)
			begin
				if (!i_pg_start[k])
				begin
					o_pg_pulse[k] <= 1'b0;
					cnt_q[k]      <= 0;
				end
				else if (cnt_q[k] == PG_HALF - 1)
				begin
					o_pg_pulse[k] <= !o_pg_pulse[k];
					cnt_q[k]      <= 0;
				end
				else
					cnt_q[k] <= cnt_q[k] + 1;
			end
		end
	end
endmodule // waveform_partner

// ### verification/waveform_unit_chk.sv
`timescale 1ns/1ps
module waveform_unit_chk
(
	// Clock and reset
	input wire logic                                                 i_mclk,
	input wire logic                                                 i_rst_n,
	// Controls
	input wire waveform_pkg::pair_cfg_t [waveform_pkg::NUM_PAIRS-1:0] i_pair_cfg,
	input wire logic [waveform_pkg::NUM_PINS-1:0]                    i_invert,
	input wire logic                                                 i_nc_bypass,
	input wire logic                                                 i_port_select,
	input wire logic [waveform_pkg::NUM_PINS-1:0]                    i_port_level,
	input wire logic                                                 i_output_hold_select,
	input wire logic                                                 i_shutdown_clear,
	input wire logic                                                 i_shutdown_request_input_n,
	// Results
	input wire logic [waveform_pkg::NUM_PINS-1:0]                    o_waveform_pin,
	input wire logic [waveform_pkg::NUM_PG-1:0]                      o_pg_start,
	input wire logic [waveform_pkg::NUM_PAIRS-1:0]                   o_reload_irq,
	input wire logic                                                 o_shutdown_interrupt
);
	logic [waveform_pkg::NUM_PG-1:0] start_exp;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	always_comb
	begin
		start_exp = 4'h0;
		for (int p = 0; p < waveform_pkg::NUM_PAIRS; p++)
			start_exp[i_pair_cfg[p].pg_select] |= i_pair_cfg[p].gate_enable;
	end

	chk_irq_one_pulse: assert property (o_reload_irq[0] |=> !o_reload_irq[0])
		else $error("reload pulse longer than one cycle");
	chk_bypass_path: assert property (i_nc_bypass && !i_shutdown_request_input_n |-> o_shutdown_interrupt)
		else $error("bypass did not raise shutdown");
	chk_port_level: assert property (o_shutdown_interrupt && i_port_select |-> o_waveform_pin == i_port_level)
		else $error("pins not at port level");
	chk_hold_level: assert property (o_shutdown_interrupt && $past(o_shutdown_interrupt) && i_output_hold_select
		&& $past(i_output_hold_select) && !i_port_select && !$past(i_port_select) |-> $stable(o_waveform_pin))
		else $error("held pins moved");
	chk_start_map: assert property ($stable(start_exp) |=> o_pg_start == $past(start_exp))
		else $error("start request misrouted");
	chk_no_overlap: assert property (i_pair_cfg[0].mode[2] && i_invert == 6'h00
		&& !o_shutdown_interrupt |-> !(o_waveform_pin[0] && o_waveform_pin[1]))
		else $error("dead-time pins overlap");
	chk_shut_sticky: assert property (!i_nc_bypass && o_shutdown_interrupt && !i_shutdown_clear |=> o_shutdown_interrupt)
		else $error("shutdown dropped without clear");
	chk_shut_filtered: assert property ($rose(o_shutdown_interrupt) && !i_nc_bypass
		|-> !$past(i_shutdown_request_input_n, 2) && !$past(i_shutdown_request_input_n, 3))
		else $error("shutdown raised by short request");

	cov_shutdown: cover property ($rose(o_shutdown_interrupt));
	cov_reload: cover property (o_reload_irq[0]);
	cov_dead_rise: cover property ($rose(o_waveform_pin[1]) && i_pair_cfg[0].mode == waveform_pkg::MODE_CMP_DEAD);
endmodule // waveform_unit_chk

bind waveform_unit waveform_unit_chk u_chk (.i_mclk, .i_rst_n, .i_pair_cfg, .i_invert, .i_nc_bypass,
	.i_port_select, .i_port_level, .i_output_hold_select, .i_shutdown_clear, .i_shutdown_request_input_n,
	.o_waveform_pin, .o_pg_start, .o_reload_irq, .o_shutdown_interrupt);

// ### verification/waveform_unit_tb.sv
`timescale 1ns/1ps
module waveform_unit_tb;
	logic                                                  clk;
	logic                                                  rst_n;
	logic [2:0]                                            div_sel;
	waveform_pkg::pair_cfg_t [waveform_pkg::NUM_PAIRS-1:0] cfg;
	logic [5:0]                                            invert;
	logic                                                  nc_bypass;
	logic                                                  port_sel;
	logic [5:0]                                            port_lvl;
	logic                                                  hold;
	logic                                                  clr;
	logic [5:0]                                            cmp_lvl;
	logic                                                  req_n;
	logic [5:0]                                            cmp;
	logic [5:0]                                            pin;
	logic [3:0]                                            pg;
	logic [3:0]                                            start;
	logic [2:0]                                            irq;
	logic                                                  shut;
	int                                                    n_fail;
	int                                                    n_checks;
	int                                                    cycles;

	waveform_unit u_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_div_sel(div_sel), .i_pair_cfg(cfg), .i_invert(invert),
		.i_nc_width(8'h04), .i_nc_bypass(nc_bypass), .i_port_select(port_sel), .i_port_level(port_lvl),
		.i_output_hold_select(hold), .i_shutdown_clear(clr), .i_compare_output(cmp), .i_pg_pulse(pg),
		.i_shutdown_request_input_n(req_n), .o_waveform_pin(pin), .o_pg_start(start), .o_reload_irq(irq),
		.o_shutdown_interrupt(shut));

	waveform_partner u_far (.i_mclk(clk), .i_rst_n(rst_n), .i_cmp_level(cmp_lvl), .i_pg_start(start),
		.o_compare_output(cmp), .o_pg_pulse(pg));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end

	task test_done;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			test_done();
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task set_all(input waveform_pkg::wave_mode_t m, input logic [15:0] a, b, f, input logic g, r);
		for (int p = 0; p < 3; p++)
			cfg[p] = '{m, a, b, f, 2'(p), g, r};
	endtask

	task wait_eq(input logic [5:0] mask, val, input int lim, output int n);
		n = 0;
		while ((pin & mask) !== val && n < lim)
		begin
			tick(1);
			n++;
		end
	endtask

	task period(output int p);
		int n;
		n = 0;
		while (irq[0] !== 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		p = 0;
		do
		begin
			tick(1);
			p++;
		end
		while (irq[0] !== 1'b1 && p < 200);
	endtask

	task t_through;
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		cmp_lvl = 6'h15;
		tick(4);
		chk(pin, 6'h15);
		invert = 6'h3F;
		tick(4);
		chk(pin, 6'h2A);
		invert = 6'h00;
		cmp_lvl = 6'h00;
		tick(4);
	endtask

	task t_super;
		int n;
		set_all(waveform_pkg::MODE_SUPERPOSE, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		cmp_lvl = 6'h3F;
		tick(4);
		chk(start, 4'h0);
		chk(pin, 6'h00);
		set_all(waveform_pkg::MODE_SUPERPOSE, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0);
		tick(3);
		chk(start, 4'h7);
		wait_eq(6'h3F, 6'h3F, 20, n);
		chk(n < 20, 1'b1);
		wait_eq(6'h3F, 6'h00, 20, n);
		chk(n < 20, 1'b1);
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		cmp_lvl = 6'h00;
		tick(6);
	endtask

	task t_dead;
		int n;
		// Unequal dead times expose a swap of A and B
		set_all(waveform_pkg::MODE_CMP_DEAD, 16'h0003, 16'h000C, 16'h0000, 1'b0, 1'b0);
		tick(20);
		cmp_lvl = 6'h02;
		wait_eq(6'h02, 6'h02, 40, n);
		chk(n >= 3 && n <= 8, 1'b1);
		chk(pin[0], 1'b0);
		cmp_lvl = 6'h00;
		wait_eq(6'h01, 6'h01, 40, n);
		chk(n >= 12 && n <= 17, 1'b1);
		chk(pin[1], 1'b0);
		set_all(waveform_pkg::MODE_CMP_DEAD_F, 16'h0003, 16'h000C, 16'h0008, 1'b0, 1'b0);
		tick(4);
		// Six ticks outlast dead time A but not the filter width
		cmp_lvl = 6'h02;
		tick(6);
		cmp_lvl = 6'h00;
		wait_eq(6'h02, 6'h02, 30, n);
		chk(16'(n), 16'h001E);
		cmp_lvl = 6'h02;
		wait_eq(6'h02, 6'h02, 30, n);
		chk(n >= 13 && n <= 17, 1'b1);
		cmp_lvl = 6'h00;
		tick(40);
	endtask

	task t_gate;
		int n;
		// Window of A+B ticks opens only on an odd compare rise
		set_all(waveform_pkg::MODE_TIMER_GATE, 16'h0004, 16'h0006, 16'h0000, 1'b1, 1'b0);
		wait_eq(6'h03, 6'h03, 12, n);
		chk(16'(n), 16'h000C);
		cmp_lvl = 6'h02;
		wait_eq(6'h03, 6'h03, 12, n);
		chk(n < 12, 1'b1);
		// Through request must wait until the window has closed
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0);
		tick(3);
		chk(pin[1], pin[0]);
		tick(12);
		chk(16'(pin[1:0]), 16'h0002);
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		cmp_lvl = 6'h00;
		tick(6);
	endtask

	task t_pgdead;
		int n;
		set_all(waveform_pkg::MODE_PG_DEAD, 16'h0001, 16'h0001, 16'h0000, 1'b1, 1'b0);
		wait_eq(6'h02, 6'h02, 20, n);
		chk(n < 20, 1'b1);
		wait_eq(6'h03, 6'h01, 20, n);
		chk(n < 20, 1'b1);
		// Stop the generators only once the pair idles in through mode
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0);
		tick(12);
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		tick(6);
		// Three-tick generator pulses sit under the filter width
		set_all(waveform_pkg::MODE_PG_DEAD_F, 16'h0001, 16'h0001, 16'h0008, 1'b1, 1'b0);
		wait_eq(6'h02, 6'h02, 30, n);
		chk(16'(n), 16'h001E);
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
		tick(6);
	endtask

	task t_reload;
		int p1;
		int p2;
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0005, 1'b0, 1'b1);
		period(p1);
		period(p1);
		div_sel = 3'h1;
		period(p2);
		period(p2);
		chk(16'(p2), 16'(2 * p1));
		chk(p1 >= 5 && p1 <= 7, 1'b1);
		div_sel = 3'h0;
		set_all(waveform_pkg::MODE_THROUGH, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
	endtask

	task t_shut;
		int n;
		cmp_lvl = 6'h2D;
		hold = 1'b1;
		tick(4);
		req_n = 1'b0;
		n = 0;
		while (shut !== 1'b1 && n < 40)
		begin
			tick(1);
			n++;
		end
		chk(n >= 6 && n <= 12, 1'b1);
		chk(pin, 6'h2D);
		cmp_lvl = 6'h12;
		tick(4);
		chk(pin, 6'h2D);
		port_sel = 1'b1;
		port_lvl = 6'h33;
		tick(1);
		chk(pin, 6'h33);
		req_n = 1'b1;
		tick(12);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(3);
		chk(shut, 1'b0);
		port_sel = 1'b0;
		hold = 1'b0;
		nc_bypass = 1'b1;
		req_n = 1'b0;
		#1;
		chk(shut, 1'b1);
		tick(1);
		req_n = 1'b1;
		#1;
		chk(shut, 1'b0);
		tick(1);
		nc_bypass = 1'b0;
	endtask

	initial
	begin
		n_fail = 0;
		n_checks = 0;
		cycles = 0;
		rst_n = 1'b0;
		div_sel = 3'h0;
		cfg = '0;
		invert = 6'h00;
		nc_bypass = 1'b0;
		port_sel = 1'b0;
		port_lvl = 6'h00;
		hold = 1'b0;
		clr = 1'b0;
		cmp_lvl = 6'h00;
		req_n = 1'b1;
		tick(6);
		chk({pin, irq, shut}, 16'h0000);
		rst_n = 1'b1;
		tick(2);
		t_through();
		t_super();
		t_gate();
		t_dead();
		t_pgdead();
		t_reload();
		t_shut();
		test_done();
	end
endmodule // waveform_unit_tb
